// ### sfsbp_cfg.svh
`ifndef SFSBP_CFG_SVH
`define SFSBP_CFG_SVH
// ------------------------------------------------------------
// widths and field positions
// ------------------------------------------------------------
`define SFSBP_DATA_W 32
`define SFSBP_BV_W 4
`define SFSBP_CH_W 2
`define SFSBP_WIDE_MASK 32'hFFFF_FFFF
`define SFSBP_NARROW_MASK 32'h0000_FFFF
`define SFSBP_WIDE_BV 4'hF
`define SFSBP_NARROW_BV 4'h3
`define SFSBP_CMD_DIR_BIT 3
`define SFSBP_STAT_OK_BIT 0
// ------------------------------------------------------------
// bus clock rates and core-cycle half periods
// ------------------------------------------------------------
`define SFSBP_CORE_MHZ 40
`define SFSBP_FREQ_LO_MHZ 66
`define SFSBP_FREQ_HI_MHZ 100
`define SFSBP_HALF_HI 2'd1
`define SFSBP_HALF_LO (2'((`SFSBP_FREQ_HI_MHZ+`SFSBP_FREQ_LO_MHZ-1)/`SFSBP_FREQ_LO_MHZ))
`endif

// ### sfsbp_pkg.sv
// ------------------------------------------------------------
// shared types
// ------------------------------------------------------------
package sfsbp_pkg;
   // device end bus sequencer
   typedef enum logic [1:0] {
      SFSBP_DS_IDLE = 2'b00,
      SFSBP_DS_STAT = 2'b01,
      SFSBP_DS_WDAT = 2'b10,
      SFSBP_DS_RDAT = 2'b11
   } sfsbp_dev_st_e;
   // master end sequencer
   typedef enum logic [2:0] {
      SFSBP_MS_IDLE = 3'b000,
      SFSBP_MS_REQ = 3'b001,
      SFSBP_MS_STAT = 3'b010,
      SFSBP_MS_WACK = 3'b011,
      SFSBP_MS_RDAT = 3'b100
   } sfsbp_mst_st_e;
endpackage

// ### sfsbp_if.sv
`include "sfsbp_cfg.svh"
// ------------------------------------------------------------
// parallel fifo bus wires
// ------------------------------------------------------------
interface sfsbp_if;
   logic bus_clk;
   logic [`SFSBP_DATA_W-1:0] data_dev;
   logic [`SFSBP_DATA_W-1:0] data_mst;
   logic [`SFSBP_DATA_W-1:0] data;
   logic data_dev_oe;
   logic data_mst_oe;
   logic [`SFSBP_BV_W-1:0] byte_valid_dev;
   logic [`SFSBP_BV_W-1:0] byte_valid_mst;
   logic [`SFSBP_BV_W-1:0] byte_valid;
   logic byte_valid_dev_oe;
   logic byte_valid_mst_oe;
   logic tx_space_flag_n;
   logic rx_data_flag_n;
   logic wr_n;
   logic rd_n;
   logic oe_n;
   logic chip_reset_n;
   logic wake_out;
   logic wake_oe;
   logic spare_wake_in_n;
   // resolved levels, undriven lines float high
   assign data = data_dev_oe ? data_dev : (data_mst_oe ? data_mst : '1);
   assign byte_valid = byte_valid_dev_oe ? byte_valid_dev :
                       (byte_valid_mst_oe ? byte_valid_mst : '1);
   assign spare_wake_in_n = wake_oe ? wake_out : 1'b1;
   modport dev (
      output bus_clk, data_dev, data_dev_oe, byte_valid_dev, byte_valid_dev_oe,
      output tx_space_flag_n, rx_data_flag_n,
      input data, byte_valid, wr_n, rd_n, oe_n, chip_reset_n, spare_wake_in_n
   );
   modport mst (
      input bus_clk, data, byte_valid, tx_space_flag_n, rx_data_flag_n,
      output data_mst, data_mst_oe, byte_valid_mst, byte_valid_mst_oe,
      output wr_n, rd_n, oe_n, chip_reset_n, wake_out, wake_oe
   );
endinterface

// ### sfsbp_dev.sv
`include "sfsbp_cfg.svh"
// ------------------------------------------------------------
// fifo bus slave, device end
// ------------------------------------------------------------
// Contract
// - device outputs bus clock, two rates
// - bidirectional data, 32 or low 16 bits
// - bidirectional byte valid lines, four or two
// - space flag low only with room
// - master writes only while space flag low
// - data flag low only with data
// - master reads only while data flag low
// - multi mode: space pin is status valid
// - multi mode: data pin is receive ack
// - master write strobe fills transmit buffer
// - multi mode: write strobe requests transaction
// - single mode: read strobe drains receive buffer; multi mode: the rise after status
// - device drives bus only under output enable
// - chip reset low resets device logic
// - master holds spare wake input defined
// - multi mode: four in, four out channels
// - single mode: one channel each way
module sfsbp_dev
   import sfsbp_pkg::*;
(
   // system
   input wire logic core_clk,
   input wire logic rst,
   // straps
   input wire logic clk_fast,
   input wire logic multi_mode,
   input wire logic narrow_bus,
   // link
   sfsbp_if.dev bus,
   // transmit side, words written by the master
   output logic [`SFSBP_DATA_W-1:0] tx_word,
   output logic [`SFSBP_BV_W-1:0] tx_byte_valid,
   output logic [`SFSBP_CH_W-1:0] tx_chan,
   output logic tx_valid,
   input wire logic tx_take,
   // receive side, words for the master
   input wire logic [`SFSBP_DATA_W-1:0] rx_word,
   input wire logic [`SFSBP_BV_W-1:0] rx_byte_valid,
   input wire logic [`SFSBP_CH_W-1:0] rx_chan,
   input wire logic rx_valid,
   output logic rx_take
);
   // ------------------------------------------------------------
   // reset and strap synchronisers
   // ------------------------------------------------------------
   logic chip_rst_async;
   logic [1:0] rsync_r;
   logic dev_rst;
   logic [2:0] strap_s1_r;
   logic [2:0] strap_s2_r;
   logic fast_s;
   logic multi_s;
   logic narrow_s;
   assign chip_rst_async = rst | ~bus.chip_reset_n;
   // release is synchronised so no flop leaves reset on a stray edge
   always_ff @(posedge core_clk or posedge chip_rst_async) begin
      if (chip_rst_async) begin
         rsync_r <= 2'b11;
      end else begin
         rsync_r <= {rsync_r[0], 1'b0};
      end
   end
   assign dev_rst = rst | rsync_r[1];
   // straps may change asynchronously
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         strap_s1_r <= 3'h0;
         strap_s2_r <= 3'h0;
      end else begin
         strap_s1_r <= {clk_fast, multi_mode, narrow_bus};
         strap_s2_r <= strap_s1_r;
      end
   end
   assign fast_s = strap_s2_r[2];
   assign multi_s = strap_s2_r[1];
   assign narrow_s = strap_s2_r[0];

   // ------------------------------------------------------------
   // bus clock divider
   // ------------------------------------------------------------
   logic [1:0] div_cnt_r, div_cnt_nxt;
   logic bclk_r, bclk_nxt;
   logic [1:0] half_m1;
   logic wrap;
   logic rise_now;
   logic fall_now;
   always_comb begin
      half_m1 = (fast_s ? `SFSBP_HALF_HI : `SFSBP_HALF_LO) - 2'd1;
      wrap = (div_cnt_r >= half_m1);
      div_cnt_nxt = wrap ? 2'd0 : div_cnt_r + 2'd1;
      bclk_nxt = wrap ? ~bclk_r : bclk_r;
   end
   // kept on rst only, so the master keeps a clock through chip reset
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_cnt_r <= 2'd0;
         bclk_r <= 1'b0;
      end else begin
         div_cnt_r <= div_cnt_nxt;
         bclk_r <= bclk_nxt;
      end
   end
   assign rise_now = wrap & ~bclk_r;
   assign fall_now = wrap & bclk_r;
   assign bus.bus_clk = bclk_r;

   // ------------------------------------------------------------
   // buffers and bus sequencer
   // ------------------------------------------------------------
   sfsbp_dev_st_e st_r, st_nxt;
   logic cmd_dir_r, cmd_dir_nxt;
   logic [`SFSBP_CH_W-1:0] cmd_ch_r, cmd_ch_nxt;
   logic stat_ok_r, stat_ok_nxt;
   logic ack_r, ack_nxt;
   logic tx_full_r, tx_full_nxt;
   logic [`SFSBP_DATA_W-1:0] tx_word_r, tx_word_nxt;
   logic [`SFSBP_BV_W-1:0] tx_bv_r, tx_bv_nxt;
   logic [`SFSBP_CH_W-1:0] tx_ch_r, tx_ch_nxt;
   logic rx_full_r, rx_full_nxt;
   logic [`SFSBP_DATA_W-1:0] rx_word_r, rx_word_nxt;
   logic [`SFSBP_BV_W-1:0] rx_bv_r, rx_bv_nxt;
   logic [`SFSBP_CH_W-1:0] rx_ch_r, rx_ch_nxt;
   logic txf_pin_r, txf_pin_nxt;
   logic rxf_pin_r, rxf_pin_nxt;
   logic [`SFSBP_DATA_W-1:0] dq_pin_r, dq_pin_nxt;
   logic [`SFSBP_BV_W-1:0] bv_pin_r, bv_pin_nxt;
   logic drive_r, drive_nxt;
   logic [`SFSBP_DATA_W-1:0] dmask;
   logic [`SFSBP_BV_W-1:0] bmask;
   logic chan_ok;
   logic [`SFSBP_DATA_W-1:0] stat_word;

   // narrow variant uses low half only
   assign dmask = narrow_s ? `SFSBP_NARROW_MASK : `SFSBP_WIDE_MASK;
   // narrow variant has two byte valid lines
   assign bmask = narrow_s ? `SFSBP_NARROW_BV : `SFSBP_WIDE_BV;

   // inputs sampled at bus rise, pins launched at bus fall, so the
   // master always samples a settled level at its own rising edge
   always_comb begin
      st_nxt = st_r;
      cmd_dir_nxt = cmd_dir_r;
      cmd_ch_nxt = cmd_ch_r;
      stat_ok_nxt = stat_ok_r;
      ack_nxt = ack_r;
      tx_full_nxt = tx_full_r;
      tx_word_nxt = tx_word_r;
      tx_bv_nxt = tx_bv_r;
      tx_ch_nxt = tx_ch_r;
      rx_full_nxt = rx_full_r;
      rx_word_nxt = rx_word_r;
      rx_bv_nxt = rx_bv_r;
      rx_ch_nxt = rx_ch_r;
      txf_pin_nxt = txf_pin_r;
      rxf_pin_nxt = rxf_pin_r;
      dq_pin_nxt = dq_pin_r;
      bv_pin_nxt = bv_pin_r;
      drive_nxt = drive_r;
      chan_ok = cmd_dir_r ? ~tx_full_r : (rx_full_r & (rx_ch_r == cmd_ch_r));
      stat_word = '0;
      stat_word[`SFSBP_STAT_OK_BIT] = chan_ok;
      // user side drains and fills
      if (tx_full_r && tx_take) begin
         tx_full_nxt = 1'b0;
      end
      if (!rx_full_r && rx_valid) begin
         rx_full_nxt = 1'b1;
         rx_word_nxt = rx_word & dmask;
         rx_bv_nxt = rx_byte_valid & bmask;
         rx_ch_nxt = multi_s ? rx_chan : '0;
      end
      if (rise_now) begin
         if (!multi_s) begin
            st_nxt = SFSBP_DS_IDLE;
            // single channel write, shown room only
            if (!bus.wr_n && !txf_pin_r) begin
               tx_full_nxt = 1'b1;
               tx_word_nxt = bus.data & dmask;
               tx_bv_nxt = bus.byte_valid & bmask;
               tx_ch_nxt = '0;
            end
            // single channel read, shown data only
            if (!bus.rd_n && !rxf_pin_r) begin
               rx_full_nxt = 1'b0;
            end
         end else begin
            case (st_r)
               SFSBP_DS_IDLE: begin
                  if (!bus.wr_n) begin
                     cmd_dir_nxt = bus.data[`SFSBP_CMD_DIR_BIT];
                     cmd_ch_nxt = bus.data[`SFSBP_CH_W-1:0];
                     st_nxt = SFSBP_DS_STAT;
                  end
               end
               // decide on the answer that was shown, not a newer one
               SFSBP_DS_STAT: begin
                  if (!stat_ok_r) begin
                     st_nxt = SFSBP_DS_IDLE;
                  end else if (cmd_dir_r) begin
                     st_nxt = SFSBP_DS_WDAT;
                  end else begin
                     st_nxt = SFSBP_DS_RDAT;
                  end
               end
               SFSBP_DS_WDAT: begin
                  if (!bus.wr_n) begin
                     tx_full_nxt = 1'b1;
                     tx_word_nxt = bus.data & dmask;
                     tx_bv_nxt = bus.byte_valid & bmask;
                     tx_ch_nxt = cmd_ch_r;
                     ack_nxt = 1'b1;
                     st_nxt = SFSBP_DS_IDLE;
                  end
               end
               default: begin
                  rx_full_nxt = 1'b0;
                  st_nxt = SFSBP_DS_IDLE;
               end
            endcase
         end
      end
      // pins launched on fall
      if (fall_now) begin
         ack_nxt = 1'b0;
         bv_pin_nxt = rx_bv_r;
         if (!multi_s) begin
            txf_pin_nxt = tx_full_r;
            rxf_pin_nxt = ~rx_full_r;
            dq_pin_nxt = rx_word_r;
            drive_nxt = 1'b1;
         end else begin
            txf_pin_nxt = ~((st_r == SFSBP_DS_STAT) | (st_r == SFSBP_DS_RDAT));
            rxf_pin_nxt = ~ack_r;
            stat_ok_nxt = chan_ok;
            dq_pin_nxt = (st_r == SFSBP_DS_STAT) ? stat_word : rx_word_r;
            drive_nxt = ~txf_pin_nxt;
         end
      end
   end

   always_ff @(posedge core_clk or posedge dev_rst) begin
      if (dev_rst) begin
         st_r <= SFSBP_DS_IDLE;
         cmd_dir_r <= 1'b0;
         cmd_ch_r <= '0;
         stat_ok_r <= 1'b0;
         ack_r <= 1'b0;
         tx_full_r <= 1'b0;
         tx_word_r <= '0;
         tx_bv_r <= '0;
         tx_ch_r <= '0;
         rx_full_r <= 1'b0;
         rx_word_r <= '0;
         rx_bv_r <= '0;
         rx_ch_r <= '0;
         txf_pin_r <= 1'b1;
         rxf_pin_r <= 1'b1;
         dq_pin_r <= '0;
         bv_pin_r <= '0;
         drive_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cmd_dir_r <= cmd_dir_nxt;
         cmd_ch_r <= cmd_ch_nxt;
         stat_ok_r <= stat_ok_nxt;
         ack_r <= ack_nxt;
         tx_full_r <= tx_full_nxt;
         tx_word_r <= tx_word_nxt;
         tx_bv_r <= tx_bv_nxt;
         tx_ch_r <= tx_ch_nxt;
         rx_full_r <= rx_full_nxt;
         rx_word_r <= rx_word_nxt;
         rx_bv_r <= rx_bv_nxt;
         rx_ch_r <= rx_ch_nxt;
         txf_pin_r <= txf_pin_nxt;
         rxf_pin_r <= rxf_pin_nxt;
         dq_pin_r <= dq_pin_nxt;
         bv_pin_r <= bv_pin_nxt;
         drive_r <= drive_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // drive released the moment output enable rises
   assign bus.data_dev = dq_pin_r;
   assign bus.data_dev_oe = drive_r & ~bus.oe_n;
   assign bus.byte_valid_dev = bv_pin_r;
   assign bus.byte_valid_dev_oe = drive_r & ~bus.oe_n;
   assign bus.tx_space_flag_n = txf_pin_r;
   assign bus.rx_data_flag_n = rxf_pin_r;
   assign tx_word = tx_word_r;
   assign tx_byte_valid = tx_bv_r;
   assign tx_chan = tx_ch_r;
   assign tx_valid = tx_full_r;
   assign rx_take = ~rx_full_r;
endmodule

// ### sfsbp_mst.sv
`include "sfsbp_cfg.svh"
// ------------------------------------------------------------
// fifo bus master end, runs on the device bus clock
// ------------------------------------------------------------
module sfsbp_mst
   import sfsbp_pkg::*;
(
   // system
   input wire logic rst,
   // mode, same as device straps
   input wire logic multi_mode,
   input wire logic narrow_bus,
   input wire logic chip_reset_req,
   // link
   sfsbp_if.mst bus,
   // write side, bus clock domain
   input wire logic [`SFSBP_DATA_W-1:0] wr_word,
   input wire logic [`SFSBP_BV_W-1:0] wr_byte_valid,
   input wire logic [`SFSBP_CH_W-1:0] wr_chan,
   input wire logic wr_valid,
   output logic wr_ready,
   // read side, bus clock domain
   input wire logic rd_req,
   input wire logic [`SFSBP_CH_W-1:0] rd_chan,
   output logic [`SFSBP_DATA_W-1:0] rd_word,
   output logic [`SFSBP_BV_W-1:0] rd_byte_valid,
   output logic rd_valid,
   output logic rd_nak
);
   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   sfsbp_mst_st_e st_r, st_nxt;
   logic wr_n_r, wr_n_nxt;
   logic rd_n_r, rd_n_nxt;
   logic oe_n_r, oe_n_nxt;
   logic [`SFSBP_DATA_W-1:0] dout_r, dout_nxt;
   logic pend_r, pend_nxt;
   logic [`SFSBP_DATA_W-1:0] pw_word_r, pw_word_nxt;
   logic [`SFSBP_BV_W-1:0] pw_bv_r, pw_bv_nxt;
   logic [`SFSBP_CH_W-1:0] pw_ch_r, pw_ch_nxt;
   logic dir_r, dir_nxt;
   logic [`SFSBP_DATA_W-1:0] rd_word_r, rd_word_nxt;
   logic [`SFSBP_BV_W-1:0] rd_bv_r, rd_bv_nxt;
   logic rd_valid_r, rd_valid_nxt;
   logic nak_r, nak_nxt;
   logic crst_n_r, crst_n_nxt;
   logic wr_taken;
   logic load;
   logic want_rd;
   logic [`SFSBP_BV_W-1:0] bmask;
   logic [`SFSBP_DATA_W-1:0] cmd;

   assign bmask = narrow_bus ? `SFSBP_NARROW_BV : `SFSBP_WIDE_BV;
   // a write counts only where the device saw room too
   assign wr_taken = multi_mode ? (st_r == SFSBP_MS_WACK) & ~bus.rx_data_flag_n
                                : ~wr_n_r & ~bus.tx_space_flag_n;
   assign wr_ready = ~pend_r | wr_taken;
   assign load = wr_valid & wr_ready;

   always_comb begin
      st_nxt = st_r;
      dir_nxt = dir_r;
      dout_nxt = dout_r;
      rd_word_nxt = rd_word_r;
      rd_bv_nxt = rd_bv_r;
      rd_valid_nxt = 1'b0;
      nak_nxt = 1'b0;
      wr_n_nxt = 1'b1;
      rd_n_nxt = 1'b1;
      oe_n_nxt = oe_n_r;
      crst_n_nxt = ~chip_reset_req;
      pend_nxt = load | (pend_r & ~wr_taken);
      pw_word_nxt = load ? wr_word : pw_word_r;
      pw_bv_nxt = load ? (wr_byte_valid & bmask) : pw_bv_r;
      pw_ch_nxt = load ? wr_chan : pw_ch_r;
      cmd = '0;
      cmd[`SFSBP_CH_W-1:0] = pend_r ? pw_ch_r : rd_chan;
      cmd[`SFSBP_CMD_DIR_BIT] = pend_r;
      want_rd = rd_req & ~bus.rx_data_flag_n;
      if (!multi_mode) begin
         st_nxt = SFSBP_MS_IDLE;
         // capture where the read met a low data flag
         if (!rd_n_r && !bus.rx_data_flag_n) begin
            rd_valid_nxt = 1'b1;
            rd_word_nxt = bus.data;
            rd_bv_nxt = bus.byte_valid;
         end
         // reads take the bus, one idle cycle on turnaround
         oe_n_nxt = ~want_rd;
         // read strobe after the bus turned
         rd_n_nxt = ~(want_rd & ~oe_n_r);
         // write only while space flag low
         wr_n_nxt = ~(pend_nxt & ~want_rd & oe_n_r & ~bus.tx_space_flag_n);
         dout_nxt = pw_word_nxt;
      end else begin
         case (st_r)
            // request word with direction and channel
            SFSBP_MS_IDLE: begin
               oe_n_nxt = 1'b1;
               if (pend_r || rd_req) begin
                  wr_n_nxt = 1'b0;
                  dout_nxt = cmd;
                  dir_nxt = pend_r;
                  st_nxt = SFSBP_MS_REQ;
               end
            end
            SFSBP_MS_REQ: begin
               oe_n_nxt = 1'b0;
               st_nxt = SFSBP_MS_STAT;
            end
            // status valid carries the go bit
            SFSBP_MS_STAT: begin
               if (!bus.tx_space_flag_n) begin
                  if (!bus.data[`SFSBP_STAT_OK_BIT]) begin
                     nak_nxt = 1'b1;
                     oe_n_nxt = 1'b1;
                     st_nxt = SFSBP_MS_IDLE;
                  end else if (dir_r) begin
                     oe_n_nxt = 1'b1;
                     wr_n_nxt = 1'b0;
                     dout_nxt = pw_word_r;
                     st_nxt = SFSBP_MS_WACK;
                  end else begin
                     st_nxt = SFSBP_MS_RDAT;
                  end
               end
            end
            SFSBP_MS_WACK: begin
               if (!bus.rx_data_flag_n) begin
                  st_nxt = SFSBP_MS_IDLE;
               end
            end
            default: begin
               if (!bus.tx_space_flag_n) begin
                  rd_valid_nxt = 1'b1;
                  rd_word_nxt = bus.data;
                  rd_bv_nxt = bus.byte_valid;
                  oe_n_nxt = 1'b1;
                  st_nxt = SFSBP_MS_IDLE;
               end
            end
         endcase
      end
   end

   // everything on the bus clock rise
   always_ff @(posedge bus.bus_clk or posedge rst) begin
      if (rst) begin
         st_r <= SFSBP_MS_IDLE;
         wr_n_r <= 1'b1;
         rd_n_r <= 1'b1;
         oe_n_r <= 1'b1;
         dout_r <= '0;
         pend_r <= 1'b0;
         pw_word_r <= '0;
         pw_bv_r <= '0;
         pw_ch_r <= '0;
         dir_r <= 1'b0;
         rd_word_r <= '0;
         rd_bv_r <= '0;
         rd_valid_r <= 1'b0;
         nak_r <= 1'b0;
         crst_n_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         wr_n_r <= wr_n_nxt;
         rd_n_r <= rd_n_nxt;
         oe_n_r <= oe_n_nxt;
         dout_r <= dout_nxt;
         pend_r <= pend_nxt;
         pw_word_r <= pw_word_nxt;
         pw_bv_r <= pw_bv_nxt;
         pw_ch_r <= pw_ch_nxt;
         dir_r <= dir_nxt;
         rd_word_r <= rd_word_nxt;
         rd_bv_r <= rd_bv_nxt;
         rd_valid_r <= rd_valid_nxt;
         nak_r <= nak_nxt;
         crst_n_r <= crst_n_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // master owns data lines while output enable is high
   assign bus.data_mst = dout_r;
   assign bus.data_mst_oe = oe_n_r;
   assign bus.byte_valid_mst = pw_bv_r;
   assign bus.byte_valid_mst_oe = oe_n_r;
   assign bus.wr_n = wr_n_r;
   assign bus.rd_n = rd_n_r;
   assign bus.oe_n = oe_n_r;
   assign bus.chip_reset_n = crst_n_r;
   assign bus.wake_out = 1'b1;
   assign bus.wake_oe = 1'b1;
   assign rd_word = rd_word_r;
   assign rd_byte_valid = rd_bv_r;
   assign rd_valid = rd_valid_r;
   assign rd_nak = nak_r;
endmodule

// ### sfsbp_assertions.sv
`include "sfsbp_cfg.svh"
// ------------------------------------------------------------
// link checks
// ------------------------------------------------------------
module sfsbp_assertions (
   // clock, reset, straps
   input wire logic bus_clk,
   input wire logic rst,
   input wire logic multi_mode,
   input wire logic narrow_bus,
   // device side
   input wire logic data_dev_oe,
   input wire logic byte_valid_dev_oe,
   input wire logic [`SFSBP_BV_W-1:0] byte_valid_dev,
   input wire logic tx_space_flag_n,
   input wire logic rx_data_flag_n,
   // master side
   input wire logic wr_n,
   input wire logic rd_n,
   input wire logic oe_n
);
   // single domain, so one default clock
   default clocking cb @(posedge bus_clk); endclocking
   default disable iff (rst);
   // drive gated, and in single mode taken up whenever enabled
   AST_DATA_OE: assert property (data_dev_oe ? !oe_n : (multi_mode || oe_n))
      else $error("data drive does not follow enable");
   AST_BV_OE: assert property (byte_valid_dev_oe |-> !oe_n)
      else $error("byte valid driven without enable");
   AST_NARROW_BV: assert property (byte_valid_dev_oe && narrow_bus |-> byte_valid_dev[3:2] == 2'h0)
      else $error("upper byte valids on narrow bus");
   AST_WR_SPACE: assert property (!multi_mode && $fell(wr_n) |-> !$past(tx_space_flag_n))
      else $error("write started without space");
   AST_RD_DATA: assert property (!multi_mode && $fell(rd_n) |-> !$past(rx_data_flag_n))
      else $error("read started without data");
   AST_OE_FIRST: assert property (!multi_mode && $fell(rd_n) |-> !$past(oe_n))
      else $error("read strobe before output enable");
   AST_STATUS: assert property (multi_mode && $fell(tx_space_flag_n) |-> !$past(wr_n))
      else $error("status without request");
   AST_ACK: assert property (multi_mode && $fell(rx_data_flag_n) |-> !$past(wr_n) ##1 rx_data_flag_n)
      else $error("ack not one cycle after data");
   // main scenarios seen
   COV_ACK: cover property (multi_mode && $fell(rx_data_flag_n));
   COV_RD: cover property (!multi_mode && !rd_n && !rx_data_flag_n);
   COV_NARROW: cover property (narrow_bus && byte_valid_dev_oe);
endmodule

// ### tb.sv
`include "sfsbp_cfg.svh"
// ------------------------------------------------------------
// two-ended link bench
// ------------------------------------------------------------
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   // rst starts low so that its first rise resets the flops on the bus clock too
   logic core_clk = 0, rst = 0, clk_fast = 1, multi_mode = 1, narrow_bus = 0, chip_reset_req = 0;
   logic tx_valid, tx_take = 0, rx_valid = 0, rx_take, wr_valid = 0, wr_ready;
   logic rd_req = 0, rd_valid, rd_nak;
   logic [`SFSBP_DATA_W-1:0] tx_word, rx_word = '0, wr_word = '0, rd_word;
   logic [`SFSBP_BV_W-1:0] tx_byte_valid, rx_byte_valid = '0, wr_byte_valid = '0, rd_byte_valid;
   logic [`SFSBP_CH_W-1:0] tx_chan, rx_chan = '0, wr_chan = '0, rd_chan = '0;
   int fails = 0, checks_done = 0;
   // word in, then word seen on a 16-bit bus
   logic [35:0] rows [4][2] = '{'{36'hF_0123_4567, 36'h3_0000_4567},
      '{36'h5_A5A5_5A5A, 36'h1_0000_5A5A}, '{36'h8_FFFF_0000, 36'h0_0000_0000},
      '{36'h1_0000_FFFF, 36'h1_0000_FFFF}};
   sfsbp_if bus_if ();
   sfsbp_dev sfsbp_dev_inst (.core_clk, .rst, .clk_fast, .multi_mode, .narrow_bus, .bus(bus_if),
      .tx_word, .tx_byte_valid, .tx_chan, .tx_valid, .tx_take, .rx_word, .rx_byte_valid,
      .rx_chan, .rx_valid, .rx_take);
   sfsbp_mst sfsbp_mst_inst (.rst, .multi_mode, .narrow_bus, .chip_reset_req, .bus(bus_if),
      .wr_word, .wr_byte_valid, .wr_chan, .wr_valid, .wr_ready, .rd_req, .rd_chan, .rd_word,
      .rd_byte_valid, .rd_valid, .rd_nak);
   sfsbp_assertions sfsbp_assertions_inst (.bus_clk(bus_if.bus_clk), .rst, .multi_mode,
      .narrow_bus, .data_dev_oe(bus_if.data_dev_oe), .byte_valid_dev_oe(bus_if.byte_valid_dev_oe),
      .byte_valid_dev(bus_if.byte_valid_dev), .tx_space_flag_n(bus_if.tx_space_flag_n),
      .rx_data_flag_n(bus_if.rx_data_flag_n), .wr_n(bus_if.wr_n), .rd_n(bus_if.rd_n),
      .oe_n(bus_if.oe_n));
   // core clock, 25 ns
   always #12.5 core_clk = ~core_clk;
   task automatic finish_test();
      if (fails == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [35:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // bounded wait, polled off the sampling edge; on_low also asks for the
   // low bus clock phase, where a bus-side ready has settled before the rise
   task automatic wait_hi(ref logic s, input logic on_low = 1'b0);
      int n = 0;
      while (s !== 1'b1 || (on_low && bus_if.bus_clk !== 1'b0)) begin
         @(negedge core_clk);
         n++;
         if (n > 400) begin
            fails++;
            finish_test();
         end
      end
   endtask
   task automatic reset(input logic f, m, nw);
      @(negedge core_clk);
      rst = 1;
      {clk_fast, multi_mode, narrow_bus} = {f, m, nw};
      repeat (16) @(negedge core_clk);
      chk({tx_valid, rx_take, bus_if.rx_data_flag_n}, 3'b011);
      rst = 0;
      repeat (40) @(negedge core_clk);
   endtask
   // core cycles between two bus clock rises
   task automatic clk_per(input int exp);
      int n = 0, r = 0;
      logic p = 1;
      repeat (20) begin
         @(negedge core_clk);
         if (r == 1) n++;
         if (bus_if.bus_clk && !p) r++;
         p = bus_if.bus_clk;
      end
      chk(n, exp);
   endtask
   // master push held until a bus rise sees ready
   task automatic mwr(input logic [35:0] w, input logic [1:0] ch);
      @(negedge core_clk);
      {wr_byte_valid, wr_word} = w;
      wr_chan = ch;
      wr_valid = 1;
      wait_hi(wr_ready, 1'b1);
      @(posedge bus_if.bus_clk);
      @(negedge core_clk);
      wr_valid = 0;
   endtask
   task automatic dtx(input logic [35:0] e, input logic [1:0] ch, input logic mc);
      wait_hi(tx_valid);
      chk({tx_byte_valid, tx_word}, e);
      if (mc) chk(tx_chan, ch);
      tx_take = 1;
      @(negedge core_clk);
      tx_take = 0;
   endtask
   task automatic drx(input logic [35:0] w, input logic [1:0] ch);
      @(negedge core_clk);
      {rx_byte_valid, rx_word} = w;
      rx_chan = ch;
      rx_valid = 1;
      wait_hi(rx_take);
      @(negedge core_clk);
      rx_valid = 0;
   endtask
   task automatic mrd(input logic [35:0] e, input logic [1:0] ch);
      @(negedge core_clk);
      rd_chan = ch;
      rd_req = 1;
      wait_hi(rd_valid);
      rd_req = 0;
      chk({rd_byte_valid, rd_word}, e);
   endtask
   initial begin
      // table rows, wide fast bus then narrow slow bus
      for (int nw = 0; nw < 2; nw++) begin
         reset(!nw, 0, nw);
         clk_per(nw ? 4 : 2);
         foreach (rows[i]) begin
            mwr(rows[i][0], 2'h0);
            dtx(rows[i][nw], 2'h0, 0);
            drx(rows[i][0], 2'h0);
            mrd(rows[i][nw], 2'h0);
         end
      end
      // multi mode: write, refused read, read
      reset(1, 1, 0);
      mwr(rows[0][0], 2'h2);
      dtx(rows[0][0], 2'h2, 1);
      rd_req = 1;
      rd_chan = 2'h1;
      wait_hi(rd_nak);
      rd_req = 0;
      drx(rows[1][0], 2'h1);
      mrd(rows[1][0], 2'h1);
      // full transmit side holds the next write back
      reset(1, 0, 0);
      mwr(rows[0][0], 2'h0);
      fork
         mwr(rows[1][0], 2'h0);
      join_none
      repeat (30) @(negedge core_clk);
      chk({bus_if.tx_space_flag_n, tx_word}, {1'b1, rows[0][0][31:0]});
      dtx(rows[0][0], 2'h0, 0);
      dtx(rows[1][0], 2'h0, 0);
      // chip reset from the master empties a filled receive buffer
      drx(rows[3][0], 2'h0);
      repeat (8) @(negedge core_clk);
      chk({rx_take, bus_if.rx_data_flag_n}, 2'b00);
      chip_reset_req = 1;
      repeat (8) @(negedge core_clk);
      chip_reset_req = 0;
      repeat (8) @(negedge core_clk);
      chk({tx_valid, rx_take, bus_if.rx_data_flag_n}, 3'b011);
      finish_test();
   end
endmodule
